// ===== dv/fmc_modem_config_sva.sv
// Purpose: Port-level checks for the modem configuration block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Output effects are checked two edges after the write lands.
`timescale 1ns/1ps
module fmc_modem_config_sva
    import fmc_pkg::*;
(
    input wire logic i_ref_clk, // Clock.
    input wire logic i_rst_b, // Reset.
    input wire logic i_psel, // Select.
    input wire logic i_penable, // Enable.
    input wire logic i_pwrite, // Direction.
    input wire logic [9:0] i_paddr, // Address.
    input wire logic [31:0] i_pwdata, // Write data.
    input wire logic [3:0] i_pstrb, // Strobes.
    input wire logic o_pready, // Ready.
    input wire logic [31:0] o_prdata, // Read data.
    input wire logic o_pslverr, // Error.
    input wire logic i_carrier_detect, // Carrier.
    input wire logic o_tx_enable, // Tx on.
    input wire logic o_rx_enable, // Rx on.
    input wire logic o_tx_active, // Sending.
    input wire logic o_sine_update, // Update pulse.
    input wire logic [9:0] o_tx_amp_mv, // Amplitude.
    input wire fmc_dac_mode_e o_dac_mode, // DAC mode.
    input wire fmc_rx_src_e o_rx_src, // Rx source.
    input wire logic o_rx_high_order_en, // Filter.
    input wire logic o_ext_loopback // Ext duplex.
);
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    logic wr_cfg;
    logic wr_rts;
    assign wr_cfg = i_psel && i_penable && i_pwrite && o_pready && (i_paddr == MODEM_CONFIG_ADDR);
    assign wr_rts = wr_cfg && i_pstrb[0] && i_pwdata[0];

    // Codes above 0Fh saturate, so the law is not a plain multiply.
    function automatic logic [9:0] amp_mv(input logic [4:0] c);
        return (c > 5'h0f) ? 10'h320 : 10'h190 + 10'(c) * 10'h19;
    endfunction

    a_enable_paths: assert property (wr_cfg && i_pstrb[0] |-> ##2
        (o_tx_enable == $past(i_pwdata[3], 2)) && (o_rx_enable == $past(i_pwdata[3], 2)))
        else $error("enable outputs do not follow bit 3");
    a_amp_code: assert property (wr_cfg && i_pstrb[0] && i_pstrb[1] |-> ##2
        o_tx_amp_mv == amp_mv($past(i_pwdata[8:4], 2))) else $error("amplitude wrong");
    a_high_order: assert property (wr_cfg && i_pstrb[1] |-> ##2
        o_rx_high_order_en == $past(i_pwdata[11], 2)) else $error("filter flag wrong");
    a_ext_duplex: assert property (wr_cfg && i_pstrb[1] |-> ##2
        o_ext_loopback == $past(i_pwdata[12], 2)) else $error("duplex flag wrong");
    a_no_int_join: assert property (o_ext_loopback [*3] |->
        o_rx_src != RX_FROM_LOOPBACK) else $error("internal join with external duplex");
    a_apb_zero_wait: assert property ((i_psel && !i_penable) ##1 (i_psel && i_penable)
        |-> o_pready) else $error("ready late");
    a_rsvd_read_zero: assert property (o_pready && i_psel && !i_pwrite
        && i_paddr == MODEM_CONFIG_ADDR |-> (o_prdata[31:16] == 16'h0000)
        && (o_prdata[14:13] == 2'b00)) else $error("reserved bits read nonzero");
    a_rts_needs_clear: assert property ($rose(o_tx_active) |->
        ($past(wr_rts) && !$past(i_carrier_detect))
        || ($past(wr_rts, 2) && !$past(i_carrier_detect, 2))) else $error("send without request");
    a_off_no_send: assert property (!o_tx_enable && !$past(o_tx_enable) |->
        !o_tx_active) else $error("sending while disabled");
    a_dac_idle: assert property (!o_tx_active [*2] |->
        o_dac_mode != DAC_ACTIVE) else $error("DAC active while idle");
    a_update_gap: assert property (o_sine_update |=> !o_sine_update [*8])
        else $error("update pulses too close");

    c_send: cover property ($rose(o_tx_active));
    c_err: cover property (o_pready && o_pslverr);
    c_upd: cover property (o_sine_update);
    c_hiz: cover property (o_dac_mode == DAC_HIGH_Z);
endmodule

bind fmc_modem_config fmc_modem_config_sva chk_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_carrier_detect(i_carrier_detect), .o_tx_enable(o_tx_enable),
    .o_rx_enable(o_rx_enable), .o_tx_active(o_tx_active), .o_sine_update(o_sine_update),
    .o_tx_amp_mv(o_tx_amp_mv), .o_dac_mode(o_dac_mode), .o_rx_src(o_rx_src),
    .o_rx_high_order_en(o_rx_high_order_en), .o_ext_loopback(o_ext_loopback));

// ===== dv/tb_fmc_modem_config.sv
// Purpose: Self-checking bench for the modem configuration block.
// Assumes: APB slave answers when ready; 25 MHz clock.
// Notes: Random register values with amplitude corner codes first.
`timescale 1ns/1ps
module tb_fmc_modem_config
    import fmc_pkg::*;
;
    logic i_ref_clk, i_rst_b, i_psel, i_penable, i_pwrite;
    logic [9:0] i_paddr;
    logic [31:0] i_pwdata, rd;
    logic [3:0] i_pstrb;
    logic i_carrier_detect, i_tx_data_valid, i_tx_data_bit, err;
    logic o_pready, o_pslverr, o_tx_enable, o_rx_enable, o_tx_active, o_tone_high;
    logic o_sine_update, o_rx_high_order_en, o_ext_loopback;
    logic [31:0] o_prdata;
    logic [6:0] o_sine_step, st;
    logic [9:0] o_tx_amp_mv;
    logic [15:0] d;
    fmc_dac_mode_e o_dac_mode;
    fmc_rx_src_e o_rx_src;
    int num_errors, check_count, cycles, g;
    logic [4:0] corner [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};

    fmc_modem_config dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_carrier_detect(i_carrier_detect), .i_tx_data_valid(i_tx_data_valid),
        .i_tx_data_bit(i_tx_data_bit), .o_tx_enable(o_tx_enable), .o_rx_enable(o_rx_enable),
        .o_tx_active(o_tx_active), .o_tone_high(o_tone_high), .o_sine_update(o_sine_update),
        .o_sine_step(o_sine_step), .o_tx_amp_mv(o_tx_amp_mv), .o_dac_mode(o_dac_mode),
        .o_rx_src(o_rx_src), .o_rx_high_order_en(o_rx_high_order_en),
        .o_ext_loopback(o_ext_loopback));

    always #20 i_ref_clk = ~i_ref_clk;
////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The run is about 2000 cycles; a hang stops well short of a long wait.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
        input logic [3:0] s);
        int n;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        i_pstrb <= s;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        n = 0;
        // Ready is read at the edge itself, before that edge updates it.
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (o_pready !== 1'b1) begin
            num_errors++;
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic cfg_wr(input logic [15:0] v);
        apb(1'b1, MODEM_CONFIG_ADDR, {16'h0000, v}, 4'h3);
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic gap();
        logic [6:0] s0;
        g = 0;
        while (o_sine_update !== 1'b1 && g < 2000) begin
            @(posedge i_ref_clk);
            #1;
            g++;
        end
        s0 = o_sine_step;
        g = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            g++;
        end while (o_sine_update !== 1'b1 && g < 2000);
        st = o_sine_step - s0;
    endtask

    function automatic logic [9:0] amp_exp(input logic [4:0] c);
        return (c > 5'h0f) ? 10'h320 : 10'h190 + 10'(c) * 10'h19;
    endfunction

    function automatic fmc_rx_src_e rx_exp(input logic [15:0] v);
        if (!v[12] && v[2]) return RX_FROM_LOOPBACK;
        return v[10] ? RX_FROM_EXT_PIN : RX_FROM_LINE;
    endfunction
////////////////////////////////////////////////////////////////
    initial begin
        {i_ref_clk, i_rst_b, i_psel, i_penable, i_pwrite} = '0;
        {i_paddr, i_pwdata, i_pstrb} = '0;
        {i_carrier_detect, i_tx_data_valid, i_tx_data_bit} = '0;
        void'($urandom(32'hccf5));
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("amp reset", o_tx_amp_mv, 32'h1f4);
        chk("dac reset", o_dac_mode, DAC_MIDCODE);
        chk("enable reset", {o_tx_enable, o_rx_enable}, 0);
        chk("filter reset", o_rx_high_order_en, 0);
        chk("rx source reset", o_rx_src, RX_FROM_LINE);
        apb(1'b0, MODEM_CONFIG_ADDR, 0, 0);
        chk("cfg reset", rd, 32'h40);
        for (int i = 0; i < 24; i++) begin
            d = 16'($urandom()) & 16'hfffe;
            if (i < 4) d[8:4] = corner[i];
            cfg_wr(d);
            apb(1'b0, MODEM_CONFIG_ADDR, 0, 0);
            chk("cfg read", rd, {16'h0000, d & 16'h9fff});
            chk("amp", o_tx_amp_mv, amp_exp(d[8:4]));
            chk("filter", o_rx_high_order_en, d[11]);
            chk("ext duplex", o_ext_loopback, d[12]);
            chk("enable", {o_tx_enable, o_rx_enable}, {2{d[3]}});
            chk("rx source", o_rx_src, rx_exp(d));
            chk("dac idle", o_dac_mode, d[1] ? DAC_HIGH_Z : DAC_MIDCODE);
            chk("active", o_tx_active, 0);
        end
        cfg_wr(16'h0000);
        apb(1'b1, MODEM_CONFIG_ADDR, 32'h0000ffff, 4'h2);
        apb(1'b0, MODEM_CONFIG_ADDR, 0, 0);
        chk("lane write", rd, 32'h9f00);
        apb(1'b0, 10'h03c, 0, 0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        apb(1'b1, MODEM_STATUS_ADDR, 32'hffff, 4'hf);
        chk("status write", err, 1);
        cfg_wr(16'h0008);
        @(posedge i_ref_clk);
        i_carrier_detect <= 1'b1;
        cfg_wr(16'h0009);
        chk("carrier blocks", o_tx_active, 0);
        @(posedge i_ref_clk);
        i_carrier_detect <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        #1;
        chk("no late start", o_tx_active, 0);
        cfg_wr(16'h0009);
        chk("start", o_tx_active, 1);
        chk("dac drive", o_dac_mode, DAC_ACTIVE);
        chk("carrier tone", o_tone_high, 0);
        apb(1'b0, MODEM_STATUS_ADDR, 0, 0);
        chk("status", rd, 32'h31);
        chk("status read err", err, 0);
        gap();
        chk("low res gap", g, UPD_LO_RES_CYC);
        chk("low res step", st, 4);
        cfg_wr(16'h0209);
        gap();
        chk("high res gap", g, UPD_HI_RES_CYC);
        chk("high res step", st, 1);
        @(posedge i_ref_clk);
        i_tx_data_valid <= 1'b1;
        i_tx_data_bit <= 1'b1;
        cfg_wr(16'h8209);
        chk("high only", o_tone_high, 1);
        cfg_wr(16'h0209);
        chk("mark tone", o_tone_high, 0);
        cfg_wr(16'h020a);
        chk("stop", o_tx_active, 0);
        chk("dac float", o_dac_mode, DAC_HIGH_Z);
        print_verdict();
    end
endmodule

// ===== hdl/fmc_modem_config.sv
// Purpose: Modem configuration register with APB access and transmit control.
// Assumes: APB master per AMBA; inputs synchronous to i_ref_clk.
// Notes: Zero wait states; unmapped addresses answer with pslverr.
//
// Overview of operation
// [RULE1] Tone-high-only set: send only 2200 Hz while request-to-send holds; data ignored.
// [RULE2] Tone-high-only clear, no data queued: continuous 1200 Hz while request-to-send holds.
// [RULE3] External loopback select: no internal modulator-to-receive join; board connects it.
// [RULE4] High-order filter bit routes receive through a higher-order filter; reset off.
// [RULE5] External filter bit takes receive signal from filtered input pin.
// [RULE6] Resolution bit: 32 steps at 38.4 kHz, or 128 steps at 153.6 kHz.
// [RULE7] Amplitude 400 mV plus 25 mV per code to 0Fh; above saturates; reset 4h.
// [RULE8] Modem enable turns transmit and receive paths on; reset off.
// [RULE9] Internal loopback joins transmit to receive internally for test; reset off.
// [RULE10] Idle high-z clear: DAC at midcode 50 k when idle; set: output floats.
// [RULE11] Request-to-send written 1 starts modulation only while carrier detect is 0.
// [RULE12] Software changes buffer thresholds only while modem enable is 0.
// [RULE13] Reserved bits 14 and 13 read zero; writes to them do nothing.
`timescale 1ns/1ps
module fmc_modem_config
    import fmc_pkg::*;
(
    input wire logic i_ref_clk,            // Reference clock, 25 MHz.
    input wire logic i_rst_b,              // Synchronous reset, active low.
    input wire logic i_psel,               // APB select.
    input wire logic i_penable,            // APB enable.
    input wire logic i_pwrite,             // APB direction, 1 is write.
    input wire logic [9:0] i_paddr,        // APB byte address.
    input wire logic [31:0] i_pwdata,      // APB write data.
    input wire logic [3:0] i_pstrb,        // APB byte strobes.
    output logic o_pready,                 // APB ready.
    output logic [31:0] o_prdata,          // APB read data.
    output logic o_pslverr,                // APB error for unmapped address.
    input wire logic i_carrier_detect,     // Carrier present on the line.
    input wire logic i_tx_data_valid,      // Transmit buffer holds data.
    input wire logic i_tx_data_bit,        // Current transmit bit, 1 is mark.
    output logic o_tx_enable,              // Transmit path powered.
    output logic o_rx_enable,              // Receive path powered.
    output logic o_tx_active,              // Modulator is sending.
    output logic o_tone_high,              // 1 selects 2200 Hz, 0 selects 1200 Hz.
    output logic o_sine_update,            // Pulse per synthesis update.
    output logic [6:0] o_sine_step,        // Sine step index, 128 per period.
    output logic [9:0] o_tx_amp_mv,        // Peak-to-peak amplitude in mV.
    output fmc_dac_mode_e o_dac_mode,      // Transmit DAC drive mode.
    output fmc_rx_src_e o_rx_src,          // Receive signal source.
    output logic o_rx_high_order_en,       // Higher-order receive filter on.
    output logic o_ext_loopback            // External duplex connection expected.
);

    ////////////////////////////////////////////////////////////////////////////
    // APB access decode.

    logic setup;
    logic access;
    logic hit_cfg;
    logic hit_sts;
    logic [15:0] wmask;

    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable && o_pready;
    assign hit_cfg = (i_paddr == MODEM_CONFIG_ADDR);
    assign hit_sts = (i_paddr == MODEM_STATUS_ADDR);

    // Byte strobes gate the two low lanes; upper lanes hold no bits.
    assign wmask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}} & MODEM_CONFIG_WMASK; // [RULE13]

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register.

    logic [15:0] cfg_q, cfg_d;
    logic cfg_wr;

    assign cfg_wr = access && i_pwrite && hit_cfg;

    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr) begin
            cfg_d = (cfg_q & ~wmask) | (i_pwdata[15:0] & wmask); // [RULE13]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cfg_q <= MODEM_CONFIG_RESET; // [RULE7]
        end else begin
            cfg_q <= cfg_d;
        end
    end

    logic tone_high_only;
    logic ext_loop;
    logic hord_en;
    logic ext_filt;
    logic hires;
    logic [4:0] amp_code;
    logic modem_enable;
    logic int_loop;
    logic idle_high_z;
    logic rts;

    assign tone_high_only = cfg_q[TONE_HIGH_ONLY_BIT];
    assign ext_loop = cfg_q[EXT_LOOPBACK_BIT];
    assign hord_en = cfg_q[RX_HIGH_ORDER_BIT];
    assign ext_filt = cfg_q[RX_EXT_FILTER_BIT];
    assign hires = cfg_q[TX_WAVE_RES_BIT];
    assign amp_code = cfg_q[TX_AMP_MSB:TX_AMP_LSB];
    assign modem_enable = cfg_q[MODEM_ENABLE_BIT];
    assign int_loop = cfg_q[INT_LOOPBACK_BIT];
    assign idle_high_z = cfg_q[TX_IDLE_HIGH_Z_BIT];
    assign rts = cfg_q[RTS_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Transmit state.

    fmc_tx_state_e st_q, st_d;
    logic rts_rise;

    // A fresh 1 in the request bit is what may start a burst; holding it at 1
    // while the carrier clears does not, so a busy line is never stolen.
    assign rts_rise = cfg_wr && wmask[RTS_BIT] && i_pwdata[RTS_BIT];

    always_comb begin
        st_d = st_q;
        case (st_q)
            TX_OFF: begin
                if (modem_enable) begin
                    st_d = TX_IDLE; // [RULE8]
                end
            end
            TX_IDLE: begin
                if (!modem_enable) begin
                    st_d = TX_OFF;
                end else if (rts_rise && !i_carrier_detect) begin
                    st_d = TX_SEND; // [RULE11]
                end
            end
            TX_SEND: begin
                if (!modem_enable) begin
                    st_d = TX_OFF;
                end else if (!rts) begin
                    st_d = TX_IDLE;
                end
            end
            default: st_d = TX_OFF;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            st_q <= TX_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered control outputs.

    logic tx_en_q, tx_en_d;
    logic rx_en_q, rx_en_d;
    logic active_q, active_d;
    logic tone_q, tone_d;
    logic [9:0] amp_mv_q, amp_mv_d;
    fmc_dac_mode_e dac_q, dac_d;
    fmc_rx_src_e src_q, src_d;
    logic hord_q, hord_d;
    logic xloop_q, xloop_d;
    logic [4:0] amp_sat;

    always_comb begin
        tx_en_d = modem_enable; // [RULE8]
        rx_en_d = modem_enable; // [RULE8]
        active_d = (st_d == TX_SEND);
        if (tone_high_only) begin
            tone_d = 1'b1; // [RULE1]
        end else if (!i_tx_data_valid) begin
            tone_d = 1'b0; // [RULE2]
        end else begin
            tone_d = !i_tx_data_bit;
        end
        amp_sat = (amp_code >= TX_AMP_SAT_CODE) ? TX_AMP_SAT_CODE : amp_code; // [RULE7]
        amp_mv_d = TX_AMP_BASE_MV + 10'(amp_sat) * 10'(TX_AMP_STEP_MV); // [RULE7]
        if (active_d) begin
            dac_d = DAC_ACTIVE;
        end else if (idle_high_z) begin
            dac_d = DAC_HIGH_Z; // [RULE10]
        end else begin
            dac_d = DAC_MIDCODE; // [RULE10]
        end
        // The external join overrides the internal one: driving both would
        // short the modulator onto whatever the board feeds back.
        if (ext_loop) begin
            src_d = ext_filt ? RX_FROM_EXT_PIN : RX_FROM_LINE; // [RULE3]
        end else if (int_loop) begin
            src_d = RX_FROM_LOOPBACK; // [RULE9]
        end else if (ext_filt) begin
            src_d = RX_FROM_EXT_PIN; // [RULE5]
        end else begin
            src_d = RX_FROM_LINE;
        end
        hord_d = hord_en; // [RULE4]
        xloop_d = ext_loop; // [RULE3]
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            tx_en_q <= 1'b0;
            rx_en_q <= 1'b0;
            active_q <= 1'b0;
            tone_q <= 1'b0;
            amp_mv_q <= '0;
            dac_q <= DAC_MIDCODE;
            src_q <= RX_FROM_LINE;
            hord_q <= 1'b0;
            xloop_q <= 1'b0;
        end else begin
            tx_en_q <= tx_en_d;
            rx_en_q <= rx_en_d;
            active_q <= active_d;
            tone_q <= tone_d;
            amp_mv_q <= amp_mv_d;
            dac_q <= dac_d;
            src_q <= src_d;
            hord_q <= hord_d;
            xloop_q <= xloop_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sine step sequencer.

    fmc_synth_if sif ();

    assign sif.run = active_q;
    assign sif.tone_high = tone_q; // [RULE1]
    assign sif.hires = hires; // [RULE6]

    fmc_tone_synth u_synth (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .sif       (sif.synth)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: loaded in the setup cycle, shown in the access cycle.

    logic rdy_q, rdy_d;
    logic err_q, err_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] status;

    assign status = {8'h00, 2'b00, st_q, 1'b0, i_carrier_detect, tone_q, active_q};

    always_comb begin
        rdy_d = 1'b0;
        err_d = 1'b0;
        rdata_d = rdata_q;
        if (setup) begin
            rdy_d = 1'b1;
            if (hit_cfg) begin
                rdata_d = {16'h0000, cfg_q}; // [RULE13]
            end else if (hit_sts) begin
                rdata_d = {16'h0000, status};
                err_d = i_pwrite;
            end else begin
                rdata_d = '0;
                err_d = 1'b1;
            end
        end else if (cfg_wr) begin
            rdata_d = {16'h0000, cfg_d};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            rdy_q <= rdy_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_pready = rdy_q;
    assign o_pslverr = err_q;
    assign o_prdata = rdata_q;
    assign o_tx_enable = tx_en_q;
    assign o_rx_enable = rx_en_q;
    assign o_tx_active = active_q;
    assign o_tone_high = tone_q;
    assign o_sine_update = sif.update;
    assign o_sine_step = sif.step;
    assign o_tx_amp_mv = amp_mv_q;
    assign o_dac_mode = dac_q;
    assign o_rx_src = src_q;
    assign o_rx_high_order_en = hord_q;
    assign o_ext_loopback = xloop_q;

endmodule

// ===== hdl/fmc_pkg.sv
// Purpose: Shared constants for the modem configuration block.
// Assumes: 25 MHz reference clock, APB with 32-bit data.
// Notes: Register byte address is four times the register index.
package fmc_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;

    // Register map: indices and byte addresses.
    localparam logic [7:0] MODEM_CONFIG_IDX = 8'h0e;
    localparam logic [7:0] MODEM_STATUS_IDX = 8'h20;
    localparam logic [9:0] MODEM_CONFIG_ADDR = {MODEM_CONFIG_IDX, 2'b00};
    localparam logic [9:0] MODEM_STATUS_ADDR = {MODEM_STATUS_IDX, 2'b00};

    // Field positions of modem_config.
    localparam int unsigned TONE_HIGH_ONLY_BIT = 15;
    localparam int unsigned EXT_LOOPBACK_BIT = 12;
    localparam int unsigned RX_HIGH_ORDER_BIT = 11;
    localparam int unsigned RX_EXT_FILTER_BIT = 10;
    localparam int unsigned TX_WAVE_RES_BIT = 9;
    localparam int unsigned TX_AMP_LSB = 4;
    localparam int unsigned TX_AMP_MSB = 8;
    localparam int unsigned MODEM_ENABLE_BIT = 3;
    localparam int unsigned INT_LOOPBACK_BIT = 2;
    localparam int unsigned TX_IDLE_HIGH_Z_BIT = 1;
    localparam int unsigned RTS_BIT = 0;

    localparam logic [15:0] MODEM_CONFIG_RESET = 16'h0040;
    localparam logic [15:0] MODEM_CONFIG_WMASK = 16'h9fff;

    // Amplitude law: 400 mV plus 25 mV per code, saturating at code 10h.
    localparam logic [4:0] TX_AMP_SAT_CODE = 5'h10;
    localparam logic [9:0] TX_AMP_BASE_MV = 10'h190;
    localparam logic [4:0] TX_AMP_STEP_MV = 5'h19;

    // Sine synthesis timing.
    localparam int unsigned TONE_LOW_HZ = 1200;
    localparam int unsigned TONE_HIGH_HZ = 2200;
    localparam int unsigned UPD_LO_RES_HZ = 38_400;
    localparam int unsigned UPD_HI_RES_HZ = 153_600;
    localparam int unsigned UPD_LO_RES_CYC = CLK_HZ / UPD_LO_RES_HZ;
    localparam int unsigned UPD_HI_RES_CYC = CLK_HZ / UPD_HI_RES_HZ;

    // Phase accumulator: top 7 bits index a 128-step period.
    localparam int unsigned PH_W = 16;
    localparam int unsigned PH_FRAC = PH_W - 7;
    localparam int unsigned INC_HI_RES_LOW = 1 << PH_FRAC;
    localparam int unsigned INC_LO_RES_LOW = 4 << PH_FRAC;
    localparam int unsigned INC_HI_RES_HIGH =
        (INC_HI_RES_LOW * TONE_HIGH_HZ + TONE_LOW_HZ / 2) / TONE_LOW_HZ;
    localparam int unsigned INC_LO_RES_HIGH =
        (INC_LO_RES_LOW * TONE_HIGH_HZ + TONE_LOW_HZ / 2) / TONE_LOW_HZ;

    typedef enum logic [1:0] {
        TX_OFF  = 2'b00,
        TX_IDLE = 2'b01,
        TX_SEND = 2'b11
    } fmc_tx_state_e;

    typedef enum logic [1:0] {
        DAC_MIDCODE = 2'b00,
        DAC_HIGH_Z  = 2'b01,
        DAC_ACTIVE  = 2'b10
    } fmc_dac_mode_e;

    typedef enum logic [1:0] {
        RX_FROM_LINE     = 2'b00,
        RX_FROM_LOOPBACK = 2'b01,
        RX_FROM_EXT_PIN  = 2'b10
    } fmc_rx_src_e;

endpackage

// ===== hdl/fmc_synth_if.sv
// Purpose: Carries control and step output between config and synthesiser.
// Assumes: Single clock domain.
// Notes: None.
`timescale 1ns/1ps
interface fmc_synth_if;
    logic run;
    logic tone_high;
    logic hires;
    logic update;
    logic [6:0] step;

    modport ctrl (output run, output tone_high, output hires, input update, input step);
    modport synth (input run, input tone_high, input hires, output update, output step);
endinterface

// ===== hdl/fmc_tone_synth.sv
// Purpose: Sine step sequencer for the two transmit tones.
// Assumes: 25 MHz clock; step index addresses a 128-entry period.
// Notes: Low resolution advances the index four at a time for the 1200 Hz tone.
`timescale 1ns/1ps
module fmc_tone_synth
    import fmc_pkg::*;
(
    input wire logic i_ref_clk,   // Reference clock.
    input wire logic i_rst_b,     // Synchronous reset, active low.
    fmc_synth_if.synth sif        // Control in, step out.
);

    logic [9:0] div_q, div_d;
    logic [PH_W-1:0] ph_q, ph_d;
    logic upd_q, upd_d;
    logic [9:0] div_top;
    logic [PH_W-1:0] inc;

    always_comb begin
        div_top = sif.hires ? 10'(UPD_HI_RES_CYC - 1) : 10'(UPD_LO_RES_CYC - 1); // [RULE6]
        case ({sif.hires, sif.tone_high})
            2'b00: inc = PH_W'(INC_LO_RES_LOW);
            2'b01: inc = PH_W'(INC_LO_RES_HIGH);
            2'b10: inc = PH_W'(INC_HI_RES_LOW);
            default: inc = PH_W'(INC_HI_RES_HIGH);
        endcase
        div_d = div_q;
        ph_d = ph_q;
        upd_d = 1'b0;
        if (!sif.run) begin
            // Restart each burst at phase zero so the carrier starts cleanly.
            div_d = '0;
            ph_d = '0;
        end else if (div_q >= div_top) begin
            div_d = '0;
            ph_d = ph_q + inc;
            upd_d = 1'b1;
        end else begin
            div_d = div_q + 10'h001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            div_q <= '0;
            ph_q <= '0;
            upd_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ph_q <= ph_d;
            upd_q <= upd_d;
        end
    end

    assign sif.update = upd_q;
    assign sif.step = ph_q[PH_W-1 -: 7];

endmodule
